/* File: bench/rbdsg_assertions.sv */
// Purpose: bus decode checks
// Assumes: clk_en_i high
// Notes: bus pins reach outputs in 3 cycles, power_good_i in 4
`timescale 1ns/1ps
module rbdsg_assertions #(
   parameter ADDR_W = 17,
   parameter HOLD_CYC = 20
) (
   input wire clk_sys_i,
   input wire sys_rst_i,
   input wire [ADDR_W-1:0] addr_i,
   input wire ce_n_i,
   input wire oe_n_i,
   input wire we_n_i,
   input wire power_good_i,
   input wire data_oe_o,
   input wire ram_chip_select_out_n_o,
   input wire ram_output_enable_out_n_o,
   input wire power_fail_out_n_o
);
   reg [31:0] good_q = 32'h0;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   always @(posedge clk_sys_i)
      good_q <= power_good_i ? good_q + 32'h1 : 32'h0;
   AST_FAIL: assert property (!power_good_i [*5] |-> !power_fail_out_n_o)
      else $error("pfo not set");
   AST_CS: assert property (!power_good_i [*5] |-> ram_chip_select_out_n_o)
      else $error("cs not blocked");
   AST_HOLD: assert property ($rose(power_fail_out_n_o) |-> good_q >= HOLD_CYC)
      else $error("hold short");
   AST_QUIET: assert property (!power_fail_out_n_o &&
      !$past(power_fail_out_n_o) |-> !data_oe_o) else $error("driven in fail");
   AST_INT: assert property ($past(addr_i, 3) < 64 |->
      ram_output_enable_out_n_o) else $error("ram oe on internal");
   AST_FWD: assert property (power_fail_out_n_o && !$past(ce_n_i, 3) &&
      $past(power_fail_out_n_o) && $past(addr_i, 3) >= 64 |->
      ram_output_enable_out_n_o == $past(oe_n_i, 3)) else $error("oe not passed");
   AST_DRV: assert property (data_oe_o |-> !$past(ce_n_i, 3) &&
      !$past(oe_n_i, 3) && $past(we_n_i, 3) && $past(addr_i, 3) < 64)
      else $error("bad drive");
   AST_WEZ: assert property ($fell(we_n_i) |-> ##3 !data_oe_o)
      else $error("drive kept");
endmodule // rbdsg_assertions
bind rbdsg_top rbdsg_assertions #(.ADDR_W(ADDR_W), .HOLD_CYC(HOLD_CYC))
   rbdsg_assertions_i (.clk_sys_i, .sys_rst_i, .addr_i, .ce_n_i, .oe_n_i,
   .we_n_i, .power_good_i, .data_oe_o, .ram_chip_select_out_n_o,
   .ram_output_enable_out_n_o, .power_fail_out_n_o);

/* File: bench/rbdsg_sram_model.sv */
// Purpose: external sram stand-in
// Assumes: low address byte only
// Notes: released bus shows inverted last byte
`timescale 1ns/1ps
module rbdsg_sram_model (
   input wire cs_n_i,
   input wire oe_n_i,
   input wire we_n_i,
   input wire [7:0] addr_i,
   input wire [7:0] data_i,
   output wire drive_o,
   output wire [7:0] data_o
);
   reg [7:0] mem [0:255];
   reg [7:0] last_q = 8'h00;
   assign drive_o = !cs_n_i && !oe_n_i;
   assign data_o = drive_o ? mem[addr_i] : ~last_q;
   always @(posedge we_n_i) if (!cs_n_i) mem[addr_i] <= data_i;
   always @(negedge drive_o) last_q <= mem[addr_i];
endmodule // rbdsg_sram_model

/* File: bench/tb_rtc_bus_decode_sram_guard.sv */
// Purpose: bench for bus decode and sram guard
// Assumes: hold shortened to 20 cycles
// Notes: inputs change on falling edge
`timescale 1ns/1ps
module tb_rtc_bus_decode_sram_guard;
   reg clk = 1'b0, rst = 1'b1, ce_n = 1'b1, oe_n = 1'b1, we_n = 1'b1;
   reg pg = 1'b0, xs = 1'b0;
   reg [16:0] addr = 17'h0;
   reg [7:0] hd = 8'h00;
   wire [7:0] dout, rq, cmd, bus;
   wire doe, rcs_n, roe_n, pfo_n, rdrv;
   integer fails = 0, checked = 0, cyc = 0, i;
   assign bus = doe ? dout : rdrv ? rq : hd;
   rbdsg_top #(.HOLD_CYC(20)) rbdsg_top_i (.clk_sys_i(clk), .sys_rst_i(rst),
      .clk_en_i(1'b1), .addr_i(addr), .data_i(bus), .data_o(dout),
      .data_oe_o(doe), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .power_good_i(pg), .ram_chip_select_out_n_o(rcs_n),
      .ram_output_enable_out_n_o(roe_n), .power_fail_out_n_o(pfo_n),
      .xfer_stb_i(xs), .xfer_data_i({14{8'h27}}), .cmd_o(cmd));
   rbdsg_sram_model rbdsg_sram_model_i (.cs_n_i(rcs_n), .oe_n_i(roe_n),
      .we_n_i(we_n), .addr_i(addr[7:0]), .data_i(bus), .drive_o(rdrv),
      .data_o(rq));
   always #10 clk = ~clk;
   task chk(input string n, input [7:0] s, input [7:0] e);
      checked = checked + 1;
      if (s !== e) begin
         fails = fails + 1;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task idle(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task wr(input [16:0] a, input [7:0] d);
      addr = a;
      oe_n = 1'b1;
      hd = d;
      ce_n = 1'b0;
      idle(4);
      we_n = 1'b0;
      idle(4);
      we_n = 1'b1;
      idle(4);
      ce_n = 1'b1;
      idle(4);
   endtask
   task rd(input [16:0] a, input [7:0] e, input ext);
      addr = a;
      ce_n = 1'b0;
      oe_n = 1'b0;
      idle(4);
      chk("data", bus, e);
      chk("ram oe", {7'h0, roe_n}, {7'h0, !ext});
      chk("drive", {7'h0, doe}, {7'h0, !ext});
      oe_n = 1'b1;
      ce_n = 1'b1;
      idle(4);
   endtask
   function [16:0] av(input integer k);
      av = (k == 3) ? 17'h3f : 17'(11 * k);
   endfunction
   function [7:0] dv(input integer k);
      dv = (k == 1) ? 8'h80 : 8'(8'h50 + k);
   endfunction
   task conclude;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 2000) begin
         fails = fails + 1;
         conclude;
      end
   end
   initial begin
      idle(16);
      rst = 1'b0;
      idle(6);
      chk("pfo", pfo_n, 0);
      chk("cs", rcs_n, 1);
      pg = 1'b1;
      idle(12);
      chk("pfo", pfo_n, 0);
      idle(20);
      chk("pfo", pfo_n, 1);
      rd(17'h0e, 8'h00, 0);
      for (i = 0; i < 4; i = i + 1) wr(av(i), dv(i));
      for (i = 0; i < 4; i = i + 1) rd(av(i), dv(i), 0);
      wr(17'h1ff40, 8'hc3);
      wr(17'h1ffff, 8'h3c);
      rd(17'h1ff40, 8'hc3, 1);
      rd(17'h1ffff, 8'h3c, 1);
      rd(17'h0, 8'h50, 0);
      xs = 1'b1;
      idle(1);
      xs = 1'b0;
      idle(2);
      rd(17'h0, 8'h27, 0);
      rd(17'h0d, 8'h27, 0);
      rd(17'h0b, 8'h80, 0);
      chk("cmd", cmd, 8'h80);
      hd = 8'h6e;
      addr = 17'h0e;
      ce_n = 1'b0;
      oe_n = 1'b0;
      idle(4);
      chk("drive", {7'h0, doe}, 8'h01);
      we_n = 1'b0;
      idle(4);
      chk("drive", {7'h0, doe}, 8'h00);
      we_n = 1'b1;
      idle(4);
      oe_n = 1'b1;
      ce_n = 1'b1;
      idle(4);
      rd(17'h0e, 8'h6e, 0);
      pg = 1'b0;
      idle(6);
      wr(17'h40, 8'h99);
      wr(17'h16, 8'h99);
      pg = 1'b1;
      idle(30);
      rd(17'h16, 8'h52, 0);
      rd(17'h40, 8'hc3, 1);
      conclude;
   end
endmodule // tb_rtc_bus_decode_sram_guard

/* File: hw/rbdsg_consts.vh */
// Purpose: constants for the rtc bus decode and sram guard
// Assumes: 50 MHz system clock
// Notes: offsets are byte addresses on the host bus
`ifndef RBDSG_CONSTS_VH
`define RBDSG_CONSTS_VH
`define RBDSG_ADDR_W 17
`define RBDSG_INT_LAST 17'h0003f
`define RBDSG_EXT_FIRST 17'h00040
`define RBDSG_NUM_LOC 64
`define RBDSG_OFF_TD0 6'h00
`define RBDSG_OFF_TD1 6'h01
`define RBDSG_OFF_TD2 6'h02
`define RBDSG_OFF_AL3 6'h03
`define RBDSG_OFF_TD4 6'h04
`define RBDSG_OFF_AL5 6'h05
`define RBDSG_OFF_TD6 6'h06
`define RBDSG_OFF_AL7 6'h07
`define RBDSG_OFF_TD8 6'h08
`define RBDSG_OFF_TD9 6'h09
`define RBDSG_OFF_TDA 6'h0a
`define RBDSG_OFF_CMD 6'h0b
`define RBDSG_OFF_WDL 6'h0c
`define RBDSG_OFF_WDH 6'h0d
`define RBDSG_OFF_USER 6'h0e
`define RBDSG_NUM_CLK_REGS 14
`define RBDSG_CMD_TE 7
`define RBDSG_LOC_RESET 8'h00
`define RBDSG_HOLD_MS 150
`define RBDSG_CLK_HZ 50000000
`define RBDSG_HOLD_CYC ((`RBDSG_CLK_HZ / 1000) * `RBDSG_HOLD_MS)
`endif

/* File: hw/rbdsg_top.v */
// Purpose: host bus decode, on-chip register file and sram guard
// Assumes: strobes and power-good arrive asynchronously
// Notes: clock counting logic sits outside; it loads via the xfer_stb_i and xfer_data_i ports
`timescale 1ns/1ps
`include "rbdsg_consts.vh"
module rbdsg_top #(
   parameter ADDR_W = `RBDSG_ADDR_W,
   parameter HOLD_CYC = `RBDSG_HOLD_CYC
) (
   input wire clk_sys_i,
   input wire sys_rst_i,
   input wire clk_en_i,
   input wire [ADDR_W-1:0] addr_i,
   input wire [7:0] data_i,
   output reg [7:0] data_o,
   output reg data_oe_o,
   input wire ce_n_i,
   input wire oe_n_i,
   input wire we_n_i,
   input wire power_good_i,
   output reg ram_chip_select_out_n_o,
   output reg ram_output_enable_out_n_o,
   output reg power_fail_out_n_o,
   input wire xfer_stb_i,
   input wire [8*`RBDSG_NUM_CLK_REGS-1:0] xfer_data_i,
   output reg [7:0] cmd_o
);
   localparam CNT_W = 24;
   localparam IDX_W = 6;
   localparam NUM_LOC = `RBDSG_NUM_LOC;
   localparam [31:0] HOLD_LAST_W = HOLD_CYC - 1;
   localparam [CNT_W-1:0] HOLD_LAST = HOLD_LAST_W[CNT_W-1:0];
   localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
   localparam [NUM_LOC-1:0] HOT_ONE = {{(NUM_LOC-1){1'b0}}, 1'b1};
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_READ = 2'h1;
   localparam [1:0] ST_WRITE = 2'h2;

   // first synchroniser stage
   reg [ADDR_W-1:0] addr_m_q;
   reg [7:0] data_m_q;
   reg ce_n_m_q;
   reg oe_n_m_q;
   reg we_n_m_q;
   reg pg_m_q;
   // second stage, the only one logic reads
   reg [ADDR_W-1:0] addr_s_q;
   reg [7:0] data_s_q;
   reg ce_n_s_q;
   reg oe_n_s_q;
   reg we_n_s_q;
   reg pg_s_q;

   // power fail and hold
   reg fail_q;
   reg fail_d;
   reg [CNT_W-1:0] hold_q;
   reg [CNT_W-1:0] hold_d;

   // bus cycle
   reg [1:0] st_q;
   reg [1:0] st_d;
   reg [IDX_W-1:0] wr_idx_q;
   reg [IDX_W-1:0] wr_idx_d;
   reg wr_int_q;
   reg wr_int_d;

   // on-chip locations
   reg [7:0] mem_q [0:NUM_LOC-1];
   wire [NUM_LOC-1:0] wr_hot;
   wire [NUM_LOC-1:0] loc_wr;
   wire [NUM_LOC-1:0] loc_xfer;
   wire [8*NUM_LOC-1:0] xfer_wide;
   wire commit;
   wire xfer_ok;
   integer i;

   // pin output next values
   reg [7:0] data_d;
   reg data_oe_d;
   reg ram_cs_n_d;
   reg ram_oe_n_d;
   reg pfo_n_d;
   reg [7:0] cmd_d;

   // decode
   wire sel_int;
   wire ce_ok;
   wire wr_act;
   wire rd_act;
   wire wr_end;
   wire [IDX_W-1:0] idx;

   assign idx = addr_s_q[IDX_W-1:0];
   assign sel_int = (addr_s_q <= `RBDSG_INT_LAST);
   assign ce_ok = ~ce_n_s_q & ~fail_q;
   assign rd_act = ce_ok & we_n_s_q & ~oe_n_s_q;
   assign wr_act = ce_ok & ~we_n_s_q;
   assign wr_end = (st_q == ST_WRITE) & ~wr_act;
   assign commit = wr_end & wr_int_q;
   assign xfer_ok = xfer_stb_i & ~commit &
      mem_q[`RBDSG_OFF_CMD][`RBDSG_CMD_TE];
   assign wr_hot = HOT_ONE << wr_idx_q;

   // address synchroniser
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         addr_m_q <= {ADDR_W{1'b0}};
         addr_s_q <= {ADDR_W{1'b0}};
      end else if (clk_en_i) begin
         addr_m_q <= addr_i;
         addr_s_q <= addr_m_q;
      end
   end

   // data synchroniser
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         data_m_q <= 8'h00;
         data_s_q <= 8'h00;
      end else if (clk_en_i) begin
         data_m_q <= data_i;
         data_s_q <= data_m_q;
      end
   end

   // strobe synchronisers, idle high
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         ce_n_m_q <= 1'b1;
         ce_n_s_q <= 1'b1;
      end else if (clk_en_i) begin
         ce_n_m_q <= ce_n_i;
         ce_n_s_q <= ce_n_m_q;
      end
   end

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         oe_n_m_q <= 1'b1;
         oe_n_s_q <= 1'b1;
      end else if (clk_en_i) begin
         oe_n_m_q <= oe_n_i;
         oe_n_s_q <= oe_n_m_q;
      end
   end

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         we_n_m_q <= 1'b1;
         we_n_s_q <= 1'b1;
      end else if (clk_en_i) begin
         we_n_m_q <= we_n_i;
         we_n_s_q <= we_n_m_q;
      end
   end

   // supply synchroniser, resets to bad
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         pg_m_q <= 1'b0;
         pg_s_q <= 1'b0;
      end else if (clk_en_i) begin
         pg_m_q <= power_good_i;
         pg_s_q <= pg_m_q;
      end
   end

   // power fail and recovery hold
   always @* begin
      fail_d = fail_q;
      hold_d = hold_q;
      if (!pg_s_q) begin
         fail_d = 1'b1;
         hold_d = {CNT_W{1'b0}};
      end else if (fail_q) begin
         if (hold_q == HOLD_LAST) begin
            fail_d = 1'b0;
         end else begin
            hold_d = hold_q + CNT_ONE;
         end
      end
   end

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         fail_q <= 1'b1;
         hold_q <= {CNT_W{1'b0}};
      end else if (clk_en_i) begin
         fail_q <= fail_d;
         hold_q <= hold_d;
      end
   end

   // cycle state machine
   always @* begin
      case (st_q)
         ST_IDLE: begin
            if (wr_act)
               st_d = ST_WRITE;
            else if (rd_act)
               st_d = ST_READ;
            else
               st_d = ST_IDLE;
         end
         ST_READ: begin
            if (wr_act)
               st_d = ST_WRITE;
            else if (rd_act)
               st_d = ST_READ;
            else
               st_d = ST_IDLE;
         end
         ST_WRITE: begin
            if (wr_act)
               st_d = ST_WRITE;
            else
               st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // write target capture
   always @* begin
      wr_idx_d = wr_idx_q;
      wr_int_d = wr_int_q;
      if (wr_act) begin
         wr_idx_d = idx;
         wr_int_d = sel_int;
      end
   end

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         st_q <= ST_IDLE;
      end else if (clk_en_i) begin
         st_q <= st_d;
      end
   end

   // write target registers
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         wr_idx_q <= {IDX_W{1'b0}};
         wr_int_q <= 1'b0;
      end else if (clk_en_i) begin
         wr_idx_q <= wr_idx_d;
         wr_int_q <= wr_int_d;
      end
   end

   // per-location write and transfer enables
   genvar g;
   generate
      for (g = 0; g < NUM_LOC; g = g + 1) begin : g_loc
         assign loc_wr[g] = commit & wr_hot[g];
         if ((g < `RBDSG_NUM_CLK_REGS) &&
             (g != `RBDSG_OFF_CMD)) begin : g_clk
            assign loc_xfer[g] = xfer_ok;
            assign xfer_wide[8*g +: 8] = xfer_data_i[8*g +: 8];
         end else begin : g_usr
            // command and user bytes change only by host writes
            assign loc_xfer[g] = 1'b0;
            assign xfer_wide[8*g +: 8] = 8'h00;
         end
      end
   endgenerate

   // on-chip locations: clock, alarm, command, watchdog, user bytes
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         for (i = 0; i < NUM_LOC; i = i + 1)
            mem_q[i] <= `RBDSG_LOC_RESET;
      end else if (clk_en_i) begin
         for (i = 0; i < NUM_LOC; i = i + 1) begin
            if (loc_wr[i])
               mem_q[i] <= data_s_q;
            else if (loc_xfer[i])
               mem_q[i] <= xfer_wide[8*i +: 8];
         end
      end
   end

   // pin output next values
   always @* begin
      data_d = mem_q[idx];
      data_oe_d = rd_act & sel_int & (st_d == ST_READ);
      ram_cs_n_d = ce_n_s_q | fail_q;
      ram_oe_n_d = ~(ce_ok & ~sel_int) | oe_n_s_q;
      pfo_n_d = ~fail_q;
      cmd_d = mem_q[`RBDSG_OFF_CMD];
   end

   // pin outputs, each straight from a flop
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         data_o <= 8'h00;
      end else if (clk_en_i) begin
         data_o <= data_d;
      end
   end

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         data_oe_o <= 1'b0;
      end else if (clk_en_i) begin
         data_oe_o <= data_oe_d;
      end
   end

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         ram_chip_select_out_n_o <= 1'b1;
      end else if (clk_en_i) begin
         ram_chip_select_out_n_o <= ram_cs_n_d;
      end
   end

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         ram_output_enable_out_n_o <= 1'b1;
      end else if (clk_en_i) begin
         ram_output_enable_out_n_o <= ram_oe_n_d;
      end
   end

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         power_fail_out_n_o <= 1'b0;
      end else if (clk_en_i) begin
         power_fail_out_n_o <= pfo_n_d;
      end
   end

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         cmd_o <= 8'h00;
      end else if (clk_en_i) begin
         cmd_o <= cmd_d;
      end
   end
endmodule // rbdsg_top
